// file: inc/smr_pkg.sv
// Contract
// - index 02h holds write-only latency code; 0001b default, up to 0110b, rest reserved
// - codes 0010..0101 give read/write latency 4/2, 5/2, 6/3, 7/4
// - index 03h holds write-only drive strength code, default 0010, listed reserved codes
// - index 04h bits 2:0 report refresh rate code, read-only
// - codes 101b and 110b mean quarter interval; 110b also asks timing de-rate
// - update flag bit 7 set when rate code changed since last read
// - reading index 04h clears the update flag
// - update flag is zero after power-up
// - rate code bit 2 set means temperature above 85 degrees
// - index 05h returns fixed maker identity code
// - indices 06h and 07h return revision identity codes
// - index 08h returns type, density 0100b and bus width fields
// - calibration register write starts init, long, short or reset calibration
// - reserved calibration codes are ignored
// - calibration pin tied to supply forces default calibration, commands ignored
// - init calibration may update device info with resistor presence
// - index 10h holds write-only bank refresh mask, zero default enables refresh
package smr_pkg;
  localparam logic [7:0] IDX_LATENCY   = 8'h02;
  localparam logic [7:0] IDX_DRIVE     = 8'h03;
  localparam logic [7:0] IDX_TEMP      = 8'h04;
  localparam logic [7:0] IDX_MAKER     = 8'h05;
  localparam logic [7:0] IDX_REV_ONE   = 8'h06;
  localparam logic [7:0] IDX_REV_TWO   = 8'h07;
  localparam logic [7:0] IDX_ORG       = 8'h08;
  localparam logic [7:0] IDX_TEST      = 8'h09;
  localparam logic [7:0] IDX_CAL       = 8'h0a;
  localparam logic [7:0] IDX_BANK_MASK = 8'h10;
  localparam logic [3:0] LAT_RST       = 4'h1;
  localparam logic [3:0] LAT_MAX       = 4'h6;
  localparam logic [3:0] DRV_RST       = 4'h2;
  localparam logic [3:0] RL_RST        = 4'h3;
  localparam logic [2:0] WL_RST        = 3'h1;
  localparam logic [2:0] RATE_RST      = 3'h3;
  localparam logic [7:0] RD_RST        = 8'h00;
  localparam logic [7:0] BANK_MASK_RST = 8'h00;
  localparam logic [2:0] RATE_RSVD     = 3'h4;
  localparam logic [2:0] RATE_DERATE   = 3'h6;
  localparam logic [7:0] CAL_INIT      = 8'hff;
  localparam logic [7:0] CAL_LONG      = 8'hab;
  localparam logic [7:0] CAL_SHORT     = 8'h56;
  localparam logic [7:0] CAL_RESET     = 8'hc3;
  localparam int         TUF_BIT       = 7;
  localparam logic [1:0] ORG_TYPE      = 2'h0;
  localparam logic [3:0] ORG_DENSITY   = 4'h4;
  localparam logic [1:0] ORG_WIDTH_X32 = 2'h0;
  localparam logic [1:0] ORG_WIDTH_X16 = 2'h1;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;
  typedef enum logic [2:0] {
    CAL_NONE_C  = 3'b000,
    CAL_INIT_C  = 3'b001,
    CAL_LONG_C  = 3'b010,
    CAL_SHORT_C = 3'b011,
    CAL_RESET_C = 3'b100
  } smr_cal_type;
endpackage

// file: src/smr_bank.sv
`timescale 1ns/1ns
module smr_bank
  import smr_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] REV_ONE  = 8'h11, // arbitrary value
  parameter logic [7:0] REV_TWO  = 8'h22, // arbitrary value
  parameter logic       WIDE_X16 = 1'b0
)(
  input  wire logic       ref_clk,          // clock, 125 MHz
  input  wire logic       reset,            // async, active high
  input  wire logic       clk_en,           // freezes all state when low
  input  wire logic       wr_en,            // mode register write pulse
  input  wire logic       rd_en,            // mode register read pulse
  input  wire logic [7:0] reg_index,        // mode register index
  input  wire logic [7:0] wr_data,          // write operand
  input  wire logic [2:0] rate_code_in,     // temperature sensor rate code
  input  wire logic       cal_pin_to_supply, // strap: cal pin tied high
  input  wire logic       cal_resistor_in,  // resistor detected at init cal
  output logic      [7:0] rd_data,          // read operand
  output logic            rd_valid,         // read answer pulse
  output logic      [3:0] read_latency,     // read latency cycles
  output logic      [2:0] write_latency,    // write latency cycles
  output logic      [3:0] drive_strength,   // drive strength code
  output logic      [7:0] bank_refresh_mask, // 1 blocks refresh to bank
  output logic            derate_req,       // timing de-rate requested
  output logic            over_85c,         // temperature above 85 C
  output logic            cal_start,        // calibration start pulse
  output logic      [2:0] cal_kind,         // calibration kind
  output logic            cal_resistor_seen // resistor presence after init
);
  logic [3:0] lat_ff, nxt_lat;
  logic [3:0] drv_ff, nxt_drv;
  logic [7:0] mask_ff, nxt_mask;
  logic [2:0] rate_s1_ff, rate_s2_ff, rate_s3_ff, rate_ff, nxt_rate;
  logic       tuf_ff, nxt_tuf;
  logic [7:0] rd_ff, nxt_rd;
  logic       rdv_ff, nxt_rdv;
  logic       strap_s1_ff, strap_s2_ff, strap_s3_ff, strap_ff, nxt_strap;
  logic       res_s1_ff, res_s2_ff, res_s3_ff, res_ff, nxt_res;
  logic       cs_ff, nxt_cs;
  smr_cal_type ck_ff, nxt_ck;
  logic [3:0] rl_ff, nxt_rl;
  logic [2:0] wl_ff, nxt_wl;
  logic       derate_ff, nxt_derate;
  logic       hot_ff, nxt_hot;
  logic       wr_lat, wr_drv, wr_mask, wr_cal, rd_temp;
  smr_cal_type cal_dec;

  assign wr_lat  = wr_en && reg_index == IDX_LATENCY;
  assign wr_drv  = wr_en && reg_index == IDX_DRIVE;
  assign wr_mask = wr_en && reg_index == IDX_BANK_MASK;
  assign wr_cal  = wr_en && reg_index == IDX_CAL;
  assign rd_temp = rd_en && reg_index == IDX_TEMP;

  always_comb
  begin
    case (wr_data)
      CAL_INIT:  cal_dec = CAL_INIT_C;
      CAL_LONG:  cal_dec = CAL_LONG_C;
      CAL_SHORT: cal_dec = CAL_SHORT_C;
      CAL_RESET: cal_dec = CAL_RESET_C;
      default:   cal_dec = CAL_NONE_C;
    endcase
  end

  always_comb
  begin
    nxt_lat  = lat_ff;
    nxt_drv  = drv_ff;
    nxt_mask = mask_ff;
    // reserved codes keep the old setting rather than landing undefined
    if (wr_lat && wr_data[3:0] != 4'h0 && wr_data[3:0] <= LAT_MAX)
      nxt_lat = wr_data[3:0];
    if (wr_drv)
    begin
      case (wr_data[3:0])
        4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7: nxt_drv = wr_data[3:0];
        default: nxt_drv = drv_ff;
      endcase
    end
    if (wr_mask)
      nxt_mask = wr_data;
    // decode from the stored code, so latencies trail the write by one cycle
    case (lat_ff)
      4'h1:
      begin
        nxt_rl = 4'h3;
        nxt_wl = 3'h1;
      end
      4'h2:
      begin
        nxt_rl = 4'h4;
        nxt_wl = 3'h2;
      end
      4'h3:
      begin
        nxt_rl = 4'h5;
        nxt_wl = 3'h2;
      end
      4'h4:
      begin
        nxt_rl = 4'h6;
        nxt_wl = 3'h3;
      end
      4'h5:
      begin
        nxt_rl = 4'h7;
        nxt_wl = 3'h4;
      end
      4'h6:
      begin
        nxt_rl = 4'h8;
        nxt_wl = 3'h4;
      end
      default:
      begin
        nxt_rl = RL_RST;
        nxt_wl = WL_RST;
      end
    endcase
  end

  // sensor and straps come from outside; count a change once stages 2 and 3 agree
  always_comb
  begin
    nxt_rate   = (rate_s2_ff == rate_s3_ff) ? rate_s3_ff : rate_ff;
    nxt_tuf    = tuf_ff;
    nxt_derate = nxt_rate == RATE_DERATE;
    nxt_hot    = nxt_rate[2];
    if (rd_temp)
      nxt_tuf = 1'b0;
    // a change in the read cycle wins over the clear
    if (nxt_rate != rate_ff)
      nxt_tuf = 1'b1;
  end

  always_comb
  begin
    nxt_strap = (strap_s2_ff == strap_s3_ff) ? strap_s3_ff : strap_ff;
    nxt_cs  = 1'b0;
    nxt_ck  = ck_ff;
    nxt_res = res_ff;
    if (wr_cal && cal_dec != CAL_NONE_C && !strap_ff)
    begin
      nxt_cs = 1'b1;
      nxt_ck = cal_dec;
      if (cal_dec == CAL_INIT_C && res_s2_ff == res_s3_ff)
        nxt_res = res_s3_ff;
    end
  end

  always_comb
  begin
    nxt_rdv = rd_en;
    case (reg_index)
      IDX_TEMP:    nxt_rd = {tuf_ff, 4'h0, rate_ff};
      IDX_MAKER:   nxt_rd = MAKER_ID;
      IDX_REV_ONE: nxt_rd = REV_ONE;
      IDX_REV_TWO: nxt_rd = REV_TWO;
      IDX_ORG:     nxt_rd = {WIDE_X16 ? ORG_WIDTH_X16 : ORG_WIDTH_X32,
                             ORG_DENSITY, ORG_TYPE};
      default:     nxt_rd = RD_UNMAPPED; // write-only and test read zero
    endcase
    if (!rd_en)
      nxt_rd = rd_ff;
  end

  // configuration group
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      lat_ff  <= LAT_RST;
      drv_ff  <= DRV_RST;
      mask_ff <= BANK_MASK_RST;
      rl_ff   <= RL_RST;
      wl_ff   <= WL_RST;
    end
    else if (clk_en)
    begin
      lat_ff  <= nxt_lat;
      drv_ff  <= nxt_drv;
      mask_ff <= nxt_mask;
      rl_ff   <= nxt_rl;
      wl_ff   <= nxt_wl;
    end
  end

  // temperature group; sync stages reset to the nominal rate so no false change follows
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rate_s1_ff <= RATE_RST;
      rate_s2_ff <= RATE_RST;
      rate_s3_ff <= RATE_RST;
      rate_ff    <= RATE_RST;
      tuf_ff     <= 1'h0;
      derate_ff  <= 1'h0;
      hot_ff     <= 1'h0;
    end
    else if (clk_en)
    begin
      rate_s1_ff <= rate_code_in;
      rate_s2_ff <= rate_s1_ff;
      rate_s3_ff <= rate_s2_ff;
      rate_ff    <= nxt_rate;
      tuf_ff     <= nxt_tuf;
      derate_ff  <= nxt_derate;
      hot_ff     <= nxt_hot;
    end
  end

  // calibration group
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      strap_s1_ff <= 1'h0;
      strap_s2_ff <= 1'h0;
      strap_s3_ff <= 1'h0;
      strap_ff    <= 1'h0;
      res_s1_ff   <= 1'h0;
      res_s2_ff   <= 1'h0;
      res_s3_ff   <= 1'h0;
      res_ff      <= 1'h0;
      cs_ff       <= 1'h0;
      ck_ff       <= CAL_NONE_C;
    end
    else if (clk_en)
    begin
      strap_s1_ff <= cal_pin_to_supply;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      strap_ff    <= nxt_strap;
      res_s1_ff   <= cal_resistor_in;
      res_s2_ff   <= res_s1_ff;
      res_s3_ff   <= res_s2_ff;
      res_ff      <= nxt_res;
      cs_ff       <= nxt_cs;
      ck_ff       <= nxt_ck;
    end
  end

  // read answer group
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_ff  <= RD_RST;
      rdv_ff <= 1'h0;
    end
    else if (clk_en)
    begin
      rd_ff  <= nxt_rd;
      rdv_ff <= nxt_rdv;
    end
  end

  assign rd_data           = rd_ff;
  assign rd_valid          = rdv_ff;
  assign read_latency      = rl_ff;
  assign write_latency     = wl_ff;
  assign drive_strength    = drv_ff;
  assign bank_refresh_mask = mask_ff;
  assign derate_req        = derate_ff;
  assign over_85c          = hot_ff;
  assign cal_start         = cs_ff;
  assign cal_kind          = ck_ff;
  assign cal_resistor_seen = res_ff;

  sequence s_lat_five_taken;
    clk_en && wr_lat && wr_data[3:0] == 4'h5;
  endsequence
  sequence s_two_enabled;
    clk_en [*2];
  endsequence

  a_tuf_read_clear: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && rd_temp && nxt_rate == rate_ff |=> !tuf_ff)
    else $error("update flag not cleared by read");
  a_tuf_change_set: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && $changed(rate_ff) |-> tuf_ff)
    else $error("update flag missed a rate change");
  a_lat_reserved_keep: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && wr_lat && (wr_data[3:0] == 4'h0 || wr_data[3:0] > LAT_MAX)
    |=> $stable(lat_ff))
    else $error("reserved latency code stored");
  a_lat_map_five: assert property (@(posedge ref_clk) disable iff (reset)
    s_lat_five_taken ##1 s_two_enabled
    |-> read_latency == 4'h7 && write_latency == 3'h4)
    else $error("latency map wrong");
  a_drv_reserved_keep: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && wr_drv && wr_data[3:0] == 4'h5 |=> $stable(drive_strength))
    else $error("reserved drive code stored");
  a_cal_reserved_ign: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && wr_cal && cal_dec == CAL_NONE_C |=> !cal_start)
    else $error("reserved calibration started");
  a_cal_strap_block: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && strap_ff |=> !cal_start)
    else $error("calibration ran with pin tied");
  a_cal_start_kind: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && wr_cal && wr_data == CAL_LONG && !strap_ff
    |=> cal_start && cal_kind == CAL_LONG_C)
    else $error("long calibration not started");
  a_mask_write: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && wr_mask |=> bank_refresh_mask == $past(wr_data))
    else $error("bank mask not stored");
  a_temp_read_pad: assert property (@(posedge ref_clk) disable iff (reset)
    rd_valid && $past(reg_index) == IDX_TEMP && $past(clk_en) |-> rd_data[6:3] == 4'h0)
    else $error("temperature pad bits not zero");
  a_org_fields: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && rd_en && reg_index == IDX_ORG |=> rd_data[5:0] == {ORG_DENSITY, ORG_TYPE})
    else $error("organisation fields wrong");
endmodule // smr_bank

// file: verif/smr_ctrl_model.sv
`timescale 1ns/1ns
module smr_ctrl_model (
  input  wire logic       ref_clk,   // device clock
  input  wire logic [7:0] rd_data,   // read answer
  input  wire logic       rd_valid,  // answer strobe
  output logic            wr_en,     // write request
  output logic            rd_en,     // read request
  output logic      [7:0] reg_index, // register index
  output logic      [7:0] wr_data    // write operand
);
  initial
  begin
    wr_en = 1'h0;
    rd_en = 1'h0;
    reg_index = 8'h00;
    wr_data = 8'h00;
  end
  // released lines show the inverse so a stale value never passes for a live one
  task automatic mr_write(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge ref_clk);
    #1;
    wr_en = 1'h1;
    reg_index = idx;
    wr_data = dat;
    @(posedge ref_clk);
    #1;
    wr_en = 1'h0;
    reg_index = ~idx;
    wr_data = ~dat;
  endtask
  task automatic mr_read(input logic [7:0] idx, output logic [7:0] dat, output bit ok);
    ok = 1'b0;
    dat = 8'h00;
    @(posedge ref_clk);
    #1;
    rd_en = 1'h1;
    reg_index = idx;
    @(posedge ref_clk);
    #1;
    rd_en = 1'h0;
    reg_index = ~idx;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (rd_valid === 1'h1)
      begin
        dat = rd_data;
        ok = 1'b1;
      end
      else
      begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask
endmodule // smr_ctrl_model

// file: verif/tb.sv
`timescale 1ns/1ns
module tb;
  import smr_pkg::*;
  logic       ref_clk, reset, clk_en, cal_pin_to_supply, cal_resistor_in, wr_en, rd_en;
  logic       rd_valid, derate_req, over_85c, cal_start, cal_resistor_seen;
  logic [2:0] rate_code_in, write_latency, cal_kind, code, prev;
  logic [3:0] read_latency, drive_strength, drv;
  logic [7:0] reg_index, wr_data, rd_data, bank_refresh_mask, lat, mask;
  int         num_errors = 0;
  int         n_tests = 0;

  smr_bank #(.MAKER_ID(8'h3c), .REV_ONE(8'h47), .REV_TWO(8'h81), .WIDE_X16(1'h1)) smr_bank_inst (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en),
    .reg_index(reg_index), .wr_data(wr_data), .rate_code_in(rate_code_in),
    .cal_pin_to_supply(cal_pin_to_supply), .cal_resistor_in(cal_resistor_in),
    .rd_data(rd_data), .rd_valid(rd_valid), .read_latency(read_latency),
    .write_latency(write_latency), .drive_strength(drive_strength),
    .bank_refresh_mask(bank_refresh_mask), .derate_req(derate_req), .over_85c(over_85c),
    .cal_start(cal_start), .cal_kind(cal_kind), .cal_resistor_seen(cal_resistor_seen));
  smr_ctrl_model smr_ctrl_model_inst (.ref_clk(ref_clk), .rd_data(rd_data),
    .rd_valid(rd_valid), .wr_en(wr_en), .rd_en(rd_en), .reg_index(reg_index),
    .wr_data(wr_data));

  initial
  begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] exp_lat(input logic [3:0] c, input logic [7:0] old);
    case (c)
      4'h1: return 8'h31;
      4'h2: return 8'h42;
      4'h3: return 8'h52;
      4'h4: return 8'h63;
      4'h5: return 8'h74;
      4'h6: return 8'h84;
      default: return old;
    endcase
  endfunction
  function automatic logic [7:0] rsvd_code();
    logic [7:0] v;
    v = 8'($urandom);
    if (v inside {CAL_INIT, CAL_LONG, CAL_SHORT, CAL_RESET})
      v = v ^ 8'h01;
    return v;
  endfunction
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    smr_ctrl_model_inst.mr_read(idx, d, ok);
    if (!ok)
    begin
      num_errors++;
      print_verdict();
    end
    else
      chk(d, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // samples three cycles so a pulse landing on either edge is counted once
  task automatic cal_chk(input logic [7:0] cmd, input logic [7:0] kind);
    int         seen;
    logic [2:0] k;
    seen = 0;
    k = 3'h0;
    smr_ctrl_model_inst.mr_write(IDX_CAL, cmd);
    repeat (3)
    begin
      if (cal_start === 1'h1)
      begin
        seen++;
        k = cal_kind;
      end
      settle(1);
    end
    chk(8'(seen), (kind != 8'h00) ? 8'h01 : 8'h00);
    chk({5'h00, k}, kind);
  endtask

  initial
  begin
    reset = 1'h1;
    clk_en = 1'h1;
    rate_code_in = 3'h3;
    cal_pin_to_supply = 1'h0;
    cal_resistor_in = 1'h0;
    lat = 8'h31;
    drv = 4'h2;
    prev = 3'h3;
    void'($urandom(4));
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'h0;
    chk({read_latency, 1'h0, write_latency}, lat);
    chk({4'h0, drive_strength}, 8'h02);
    chk(bank_refresh_mask, 8'h00);
    rd(IDX_TEMP, 8'h03);
    for (int c = 0; c < 16; c++)
    begin
      smr_ctrl_model_inst.mr_write(IDX_LATENCY, {4'($urandom), 4'(c)});
      smr_ctrl_model_inst.mr_write(IDX_DRIVE, {4'($urandom), 4'(15 - c)});
      lat = exp_lat(4'(c), lat);
      if ((15 - c) inside {1, 2, 3, 4, 6, 7})
        drv = 4'(15 - c);
      settle(3);
      chk({read_latency, 1'h0, write_latency}, lat);
      chk({4'h0, drive_strength}, {4'h0, drv});
    end
    rd(IDX_LATENCY, 8'h00);
    repeat (4)
    begin
      mask = 8'($urandom);
      smr_ctrl_model_inst.mr_write(IDX_BANK_MASK, mask);
      settle(2);
      chk(bank_refresh_mask, mask);
    end
    clk_en = 1'h0;
    smr_ctrl_model_inst.mr_write(IDX_BANK_MASK, ~mask);
    clk_en = 1'h1;
    chk(bank_refresh_mask, mask);
    for (int c = 0; c < 9; c++)
    begin
      code = (c == 8) ? 3'h7 : 3'(c);
      rate_code_in = code;
      settle(6);
      chk({6'h00, derate_req, over_85c}, {6'h00, code == RATE_DERATE, code[2]});
      rd(IDX_TEMP, {code != prev, 4'h0, code});
      rd(IDX_TEMP, {5'h00, code});
      prev = code;
    end
    smr_ctrl_model_inst.mr_write(IDX_MAKER, 8'h00);
    rd(IDX_MAKER, 8'h3c);
    rd(IDX_REV_ONE, 8'h47);
    rd(IDX_REV_TWO, 8'h81);
    rd(IDX_ORG, 8'h50);
    rd(IDX_TEST, 8'h00);
    rd(8'h33, RD_UNMAPPED);
    cal_resistor_in = 1'h1;
    settle(4); // let the resistor level clear the synchroniser first
    cal_chk(CAL_INIT, 8'h01);
    chk({7'h00, cal_resistor_seen}, 8'h01);
    cal_chk(CAL_LONG, 8'h02);
    cal_chk(CAL_SHORT, 8'h03);
    cal_chk(CAL_RESET, 8'h04);
    repeat (4) cal_chk(rsvd_code(), 8'h00);
    cal_pin_to_supply = 1'h1;
    settle(5);
    cal_chk(CAL_LONG, 8'h00);
    print_verdict();
  end
endmodule // tb
